//--- hdl/ubrg_defs.svh
// Offsets, field positions, reset values and timing counts of the baud rate generator
`ifndef UBRG_DEFS_SVH
`define UBRG_DEFS_SVH
`define UBRG_OFF_MODE 12'h000
`define UBRG_OFF_DIV 12'h004
`define UBRG_OFF_TXDATA 12'h008
`define UBRG_OFF_STAT 12'h00c
`define UBRG_BIT_POWER 7
`define UBRG_BIT_TXEN 6
`define UBRG_BIT_RXEN 5
`define UBRG_BIT_POL 4
`define UBRG_BIT_DBL 3
`define UBRG_MODE_RST 8'h00
`define UBRG_DIV_RST 8'h02
`define UBRG_DIV_MIN 8'h02
`define UBRG_CNT_ZERO 8'h00
`define UBRG_FRAME_BITS 4'hb
`define UBRG_TXFRAME_BITS 4'ha
`define UBRG_RX_CMP_LAST 4'hb
`endif

//--- hdl/ubrg_pkg.sv
// Types shared by the baud rate generator files
package ubrg_pkg;
  typedef enum logic [1:0] {
    UBRG_RX_IDLE = 2'b00,
    UBRG_RX_START = 2'b01,
    UBRG_RX_DATA = 2'b10
  } ubrg_rx_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } ubrg_cnt_t;
endpackage : ubrg_pkg

//--- hdl/ubrg_counter.sv
// Half-bit counter clocked by the base clock enable
`timescale 1ns/100ps
`default_nettype none
`include "ubrg_defs.svh"
module ubrg_counter
  import ubrg_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic base_tick,
  input wire logic hold_clear,
  input wire logic sync_clear,
  input wire logic [WIDTH-1:0] divisor,
  output logic [WIDTH-1:0] count,
  output logic half_tick
);
  ubrg_cnt_t s_q;
  ubrg_cnt_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (hold_clear || sync_clear) begin
      s_d.cnt = `UBRG_CNT_ZERO;
    end else if (base_tick) begin
      // Counts 1..k, tick on reaching k
      if (s_q.cnt >= divisor) begin
        s_d.cnt = 8'h01;
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
      s_d.tick = (s_d.cnt == divisor);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;
  assign half_tick = s_q.tick;
endmodule : ubrg_counter
`default_nettype wire

//--- hdl/ubrg_top.sv
// Baud rate generator with APB registers, transmit and receive bit timing
// Operation
// - Base clock runs only while power bit set
// - Separate 8-bit transmit and receive counters
// - Transmit counter zero unless power and enable
// - First transmit write clears transmit counter
// - Each finished frame clears it when continuing
// - Without more data counter keeps counting
// - Receive counter zero unless enabled, starts on start
// - Receive counter halts after frame until start
// - Divisor k from eight bits, 2 to 255
// - Bit rate equals clock over 2k
// - Bit latch timed from receive counter, 11-bit frame, 10 latches after start
// - Port setup precedes setting the power bit
// - Level accepted after two equal samples
// - Edge starts counter, recheck at k
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "ubrg_defs.svh"
module ubrg_top
  import ubrg_pkg::*;
#(
  parameter int CNT_WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic sub_clk_tick,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_line_pin,
  output logic tx_half_tick,
  output logic rx_half_tick,
  output logic rx_bit_latch,
  output logic rx_frame_done,
  output logic tx_frame_done
);
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] div;
    logic [7:0] txbuf;
    logic txbuf_full;
    logic tx_active;
    logic [3:0] tx_bits;
    logic tx_half;
    logic tx_done;
    logic [1:0] rx_samp;
    logic rx_filt;
    logic rx_filt_prev;
    ubrg_rx_state_t rx_st;
    logic [3:0] rx_bits;
    logic rx_half;
    logic rx_latch;
    logic rx_done;
    logic dbl_phase;
    logic [31:0] rdata;
  } ubrg_top_state_t;

  ubrg_top_state_t s_q;
  ubrg_top_state_t s_d;
  logic power;
  logic tx_run;
  logic rx_run;
  logic base_tick;
  logic [7:0] tx_cnt;
  logic [7:0] rx_cnt;
  logic tx_tick;
  logic rx_tick;
  logic tx_clear;
  logic rx_clear;
  logic wr_en;
  logic rd_en;
  logic tx_wr;
  logic rx_active_level;

  assign power = s_q.mode[`UBRG_BIT_POWER];
  assign tx_run = power && s_q.mode[`UBRG_BIT_TXEN];
  assign rx_run = power && s_q.mode[`UBRG_BIT_RXEN];
  // Doubled clock gives two base ticks per sub-clock tick (that cycle and the next), plain clock one
  assign base_tick = power && (s_q.mode[`UBRG_BIT_DBL] ? (sub_clk_tick || s_q.dbl_phase)
                                                       : sub_clk_tick);
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign tx_wr = wr_en && (paddr == `UBRG_OFF_TXDATA) && tx_run && !s_q.txbuf_full;
  assign rx_active_level = s_q.mode[`UBRG_BIT_POL];

  // Clear on the first write, or at frame end when more data waits
  assign tx_clear = (tx_wr && !s_q.tx_active)
                    || (s_q.tx_done && s_q.txbuf_full);
  assign rx_clear = (s_q.rx_st == UBRG_RX_IDLE);

  ubrg_counter #(
    .WIDTH(CNT_WIDTH)
  ) u_tx_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .ce(clk_en),
    .base_tick(base_tick),
    .hold_clear(!tx_run),
    .sync_clear(tx_clear),
    .divisor(s_q.div),
    .count(tx_cnt),
    .half_tick(tx_tick)
  );

  ubrg_counter #(
    .WIDTH(CNT_WIDTH)
  ) u_rx_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .ce(clk_en),
    .base_tick(base_tick),
    .hold_clear(!rx_run),
    .sync_clear(rx_clear),
    .divisor(s_q.div),
    .count(rx_cnt),
    .half_tick(rx_tick)
  );

  always_comb begin
    s_d = s_q;
    s_d.tx_done = 1'b0;
    s_d.rx_latch = 1'b0;
    s_d.rx_done = 1'b0;
    s_d.dbl_phase = sub_clk_tick;
    // APB writes
    if (wr_en) begin
      case (paddr)
        `UBRG_OFF_MODE: s_d.mode = pwdata[7:0];
        `UBRG_OFF_DIV: begin
          // Values below 2 are not legal and are ignored
          if (pwdata[7:0] >= `UBRG_DIV_MIN) begin
            s_d.div = pwdata[7:0];
          end
        end
        default: s_d.div = s_d.div;
      endcase
    end
    // Transmit frame sequencing, two half ticks per bit
    if (!tx_run) begin
      s_d.tx_active = 1'b0;
      s_d.txbuf_full = 1'b0;
      s_d.tx_bits = 4'h0;
      s_d.tx_half = 1'b0;
    end else begin
      if (tx_clear) begin
        s_d.tx_half = 1'b0;
        s_d.tx_bits = 4'h0;
        if (s_q.txbuf_full && s_q.tx_done) begin
          s_d.txbuf_full = 1'b0;
        end
        s_d.tx_active = 1'b1;
      end else if (tx_tick && s_q.tx_active) begin
        s_d.tx_half = !s_q.tx_half;
        if (s_q.tx_half) begin
          if (s_q.tx_bits == `UBRG_TXFRAME_BITS) begin
            // Idle after frame keeps counting uncleared
            s_d.tx_bits = 4'h0;
            s_d.tx_done = 1'b1;
            s_d.tx_active = s_q.txbuf_full;
          end else begin
            s_d.tx_bits = s_q.tx_bits + 4'h1;
          end
        end
      end
      if (tx_wr) begin
        s_d.txbuf = pwdata[7:0];
        if (s_q.tx_active) begin
          s_d.txbuf_full = 1'b1;
        end
      end
    end
    // Two equal samples set the filtered level
    // Tracks the pin while unpowered, so no false edge at power-up
    if (base_tick || !power) begin
      s_d.rx_samp = {s_q.rx_samp[0], rx_line_pin};
      if (s_q.rx_samp[1] == s_q.rx_samp[0]) begin
        s_d.rx_filt = s_q.rx_samp[0];
      end
      s_d.rx_filt_prev = s_q.rx_filt;
    end
    // Receive start detection and bit timing
    if (!rx_run) begin
      s_d.rx_st = UBRG_RX_IDLE;
      s_d.rx_bits = 4'h0;
      s_d.rx_half = 1'b0;
    end else begin
      case (s_q.rx_st)
        UBRG_RX_IDLE: begin
          // Edge into the active level starts counting
          if (base_tick && (s_q.rx_filt == rx_active_level)
              && (s_q.rx_filt_prev != rx_active_level)) begin
            s_d.rx_st = UBRG_RX_START;
          end
        end
        UBRG_RX_START: begin
          if (rx_tick) begin
            if (s_q.rx_filt == rx_active_level) begin
              s_d.rx_st = UBRG_RX_DATA;
              s_d.rx_bits = 4'h1;
              s_d.rx_half = 1'b0;
            end else begin
              s_d.rx_st = UBRG_RX_IDLE;
            end
          end
        end
        UBRG_RX_DATA: begin
          if (rx_tick) begin
            s_d.rx_half = !s_q.rx_half;
            // Latch at mid-bit, every second half tick
            if (s_q.rx_half) begin
              s_d.rx_latch = 1'b1;
              if (s_q.rx_bits == (`UBRG_FRAME_BITS - 4'h1)) begin
                s_d.rx_st = UBRG_RX_IDLE;
                s_d.rx_done = 1'b1;
                s_d.rx_bits = 4'h0;
              end else begin
                s_d.rx_bits = s_q.rx_bits + 4'h1;
              end
            end
          end
        end
        default: s_d.rx_st = UBRG_RX_IDLE;
      endcase
    end
    // APB read data captured in setup phase
    if (rd_en) begin
      case (paddr)
        `UBRG_OFF_MODE: s_d.rdata = {24'h000000, s_q.mode};
        `UBRG_OFF_DIV: s_d.rdata = {24'h000000, s_q.div};
        `UBRG_OFF_TXDATA: s_d.rdata = {24'h000000, s_q.txbuf};
        `UBRG_OFF_STAT: s_d.rdata = {8'h00, rx_cnt, tx_cnt, 2'b00, s_q.rx_st,
                                     s_q.rx_filt, s_q.tx_active, s_q.txbuf_full, power};
        default: s_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.mode <= `UBRG_MODE_RST;
      s_q.div <= `UBRG_DIV_RST;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !((paddr == `UBRG_OFF_MODE) || (paddr == `UBRG_OFF_DIV)
                   || (paddr == `UBRG_OFF_TXDATA) || (paddr == `UBRG_OFF_STAT));
  assign tx_half_tick = tx_tick;
  assign rx_half_tick = rx_tick;
  assign rx_bit_latch = s_q.rx_latch;
  assign rx_frame_done = s_q.rx_done;
  assign tx_frame_done = s_q.tx_done;
endmodule : ubrg_top
`default_nettype wire

//--- verification/ubrg_sva.sv
// Port checker of the baud rate generator
`timescale 1ns/100ps
`default_nettype none
module ubrg_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sub_clk_tick,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic tx_half_tick,
  input wire logic rx_half_tick,
  input wire logic rx_bit_latch,
  input wire logic rx_frame_done,
  input wire logic tx_frame_done
);
  logic [7:0] mode_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Mode mirror from bus writes; valid only while clk_en stays high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_q <= 8'h00;
    else if (psel && penable && pwrite && paddr == 12'h000) mode_q <= pwdata[7:0];
  end
  a_tx_off_quiet: assert property ((!mode_q[7] || !mode_q[6]) [*3] |-> !tx_half_tick)
    else $error("tx tick while disabled");
  a_rx_off_quiet: assert property ((!mode_q[7] || !mode_q[5]) [*3] |-> !rx_half_tick)
    else $error("rx tick while disabled");
  a_tick_base_cause: assert property (tx_half_tick |-> $past(sub_clk_tick)
    || $past(sub_clk_tick, 2) || $past(sub_clk_tick, 3)) else $error("tick without base");
  a_tick_single: assert property (tx_half_tick |=> !tx_half_tick)
    else $error("tx tick longer than one cycle");
  a_rx_halt_after: assert property (rx_frame_done |=> !rx_half_tick [*8])
    else $error("rx counter runs after frame");
  a_latch_on_tick: assert property (rx_bit_latch |-> rx_half_tick || $past(rx_half_tick))
    else $error("bit latch off tick");
  a_done_on_latch: assert property (rx_frame_done |-> rx_bit_latch || $past(rx_bit_latch))
    else $error("frame end without latch");
  a_tx_done_tick: assert property (tx_frame_done |-> tx_half_tick || $past(tx_half_tick))
    else $error("tx frame end off tick");
endmodule : ubrg_sva
bind ubrg_top ubrg_sva i_ubrg_sva (.pclk(pclk), .presetn(presetn),
  .sub_clk_tick(sub_clk_tick), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .tx_half_tick(tx_half_tick),
  .rx_half_tick(rx_half_tick), .rx_bit_latch(rx_bit_latch),
  .rx_frame_done(rx_frame_done), .tx_frame_done(tx_frame_done));
`default_nettype wire

//--- verification/ubrg_remote_tx.sv
// Remote serial transmitter driving the receive line
`timescale 1ns/100ps
`default_nettype none
module ubrg_remote_tx (
  input wire logic pclk,
  input wire logic pol,
  input wire logic [7:0] bit_cyc,
  input wire logic [7:0] data,
  input wire logic go,
  output logic line
);
  logic [10:0] frame_q = 11'h7ff;
  logic [3:0] left_q = 4'h0;
  logic [7:0] cyc_q = 8'h00;
  // Start, eight data, parity, stop; bit time must match the receiver
  // Plain process: the initialisers above would clash with always_ff ownership
  always @(posedge pclk) begin
    if (left_q == 4'h0 && go) begin
      frame_q <= {1'b1, ^data, data, 1'b0};
      left_q <= 4'hb;
      cyc_q <= bit_cyc;
    end else if (left_q != 4'h0) begin
      if (cyc_q == 8'h01) begin
        frame_q <= {1'b1, frame_q[10:1]};
        left_q <= left_q - 4'h1;
        cyc_q <= bit_cyc;
      end else cyc_q <= cyc_q - 8'h01;
    end
  end
  assign line = (left_q == 4'h0) ? ~pol : frame_q[0] ^ pol;
endmodule : ubrg_remote_tx
`default_nettype wire

//--- verification/ubrg_top_bench.sv
// Register and bit timing tests of the baud rate generator
`timescale 1ns/100ps
`default_nettype none
module ubrg_top_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic sub_clk_tick = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, line, go = 1'b0, pol = 1'b0;
  logic tx_half_tick, rx_half_tick, rx_bit_latch, rx_frame_done, tx_frame_done;
  logic [1:0] sdiv = 2'h0;
  logic [7:0] kv [4] = '{8'h02, 8'h09, 8'hff, 8'h04};
  logic [7:0] mv [4] = '{8'hc0, 8'hc0, 8'hc0, 8'hc8};
  int gv [4] = '{2, 9, 255, 2};
  int fail_count, compares, subs, gap, last_sub, txt, lat, rxd, txd, sub_clock, fgap, n0;
  ubrg_top i_ubrg_top (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .sub_clk_tick(sub_clk_tick), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_line_pin(line), .tx_half_tick(tx_half_tick),
    .rx_half_tick(rx_half_tick), .rx_bit_latch(rx_bit_latch),
    .rx_frame_done(rx_frame_done), .tx_frame_done(tx_frame_done));
  // Bit time 2k base ticks at k=2, four cycles per sub-clock tick
  ubrg_remote_tx i_ubrg_remote_tx (.pclk(pclk), .pol(pol), .bit_cyc(8'h10),
    .data(8'h5a), .go(go), .line(line));
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    sdiv <= sdiv + 2'h1;
    sub_clk_tick <= (sdiv == 2'h3);
  end
  // Gaps measured in sub-clock ticks
  always @(posedge pclk) begin
    if (sub_clk_tick === 1'b1) subs++;
    if (tx_half_tick === 1'b1) begin
      gap = subs - last_sub;
      last_sub = subs;
      txt++;
    end
    if (rx_bit_latch === 1'b1) lat++;
    if (rx_frame_done === 1'b1) rxd++;
    if (tx_frame_done === 1'b1) begin
      fgap = subs - sub_clock;
      sub_clock = subs;
      txd++;
    end
  end
  task automatic end_of_test;
    $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    if (pready !== 1'b1) begin
      fail_count++;
      $display("[ERR] pready expected 1 seen %b", pready);
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wait_cnt(ref int c, input int want);
    int n;
    n = 0;
    while (c < want && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (c < want) begin
      fail_count++;
      $display("[ERR] event count expected %0d seen %0d", want, c);
      end_of_test();
    end
  endtask : wait_cnt
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    chk("mode_rst", 32'h0, q);
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk("div_min", 32'h2, q);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, q);
    $display("Test registers done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h004, {24'h0, kv[i]});
      apb(1'b1, 12'h000, {24'h0, mv[i]});
      wait_cnt(txt, txt + 3);
      chk("tick_gap", gv[i], gap);
      apb(1'b1, 12'h000, 32'h0);
    end
    apb(1'b0, 12'h00c, 32'h0);
    chk("tx_cnt_off", 32'h0, q & 32'h0000ff00);
    apb(1'b1, 12'h000, 32'h40);
    n0 = txt;
    repeat (100) @(posedge pclk);
    chk("tick_no_power", n0, txt);
    $display("Test rates done");
    apb(1'b1, 12'h004, 32'h14);
    apb(1'b1, 12'h000, 32'hc0);
    wait_cnt(txt, txt + 2);
    repeat (12) @(posedge pclk);
    apb(1'b1, 12'h008, 32'h11);
    apb(1'b0, 12'h00c, 32'h0);
    chk("tx_clr_first", 32'h1, {31'h0, q[15:8] < 8'h02});
    apb(1'b1, 12'h008, 32'h22);
    wait_cnt(txd, txd + 1);
    apb(1'b0, 12'h00c, 32'h0);
    chk("tx_clr_next", 32'h1, {31'h0, q[15:8] < 8'h02});
    wait_cnt(txd, txd + 1);
    chk("frame_len", 32'd440, fgap);
    wait_cnt(txt, txt + 2);
    chk("tx_free_gap", 32'd20, gap);
    $display("Test transmit done");
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h2);
    for (int p = 0; p < 2; p++) begin
      pol <= p[0];
      repeat (4) @(posedge pclk);
      apb(1'b1, 12'h000, p ? 32'hb0 : 32'ha0);
      apb(1'b0, 12'h00c, 32'h0);
      chk("rx_cnt_idle", 32'h0, q & 32'h00ff0000);
      n0 = lat;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      wait_cnt(rxd, rxd + 1);
      chk("rx_bits", 32'd10, lat - n0);
      apb(1'b0, 12'h00c, 32'h0);
      chk("rx_cnt_halt", 32'h0, q & 32'h00ff0000);
      apb(1'b1, 12'h000, 32'h0);
    end
    $display("Test receive done");
    end_of_test();
  end
endmodule : ubrg_top_bench
`default_nettype wire
